//--- rtl/ffb_pkg.sv
`default_nettype none
package ffb_pkg;
  // ==========================================================
  // sizes and instance counts
  localparam int DW        = 32;
  localparam int NUM_GRP   = 6;
  localparam int NUM_MIN_GRP = 5;
  localparam int N_ADD = 3, N_AND = 4, N_AVA = 2, N_BSW = 2, N_DFR = 3, N_DIF = 1, N_DIV = 2;
  localparam int N_INT = 1, N_LIM = 2, N_LVM = 2, N_MFP = 4, N_MUL = 2, N_NCM = 2;
  localparam int NUM_SLOTS = N_ADD + N_AND + N_AVA + N_BSW + N_DFR + N_DIF + N_DIV
                           + N_INT + N_LIM + N_LVM + N_MFP + N_MUL + N_NCM;
  localparam logic [14:0] SEQ_MAX = 15'd32000;
  // ==========================================================
  // timing
  localparam int SLICE1_MS     = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  // ==========================================================
  // register map
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] STAT_OFS  = 12'h004;
  localparam logic [5:0]  SLOT_BASE_BLK = 6'h04;
  localparam logic [3:0]  W_CFG = 4'h0, W_X0 = 4'h1, W_X3 = 4'h4, W_BIN = 4'h5, W_PAR = 4'h6;
  localparam logic [3:0]  W_Y = 4'h8, W_YQ = 4'h9, W_YR = 4'hA, W_BO = 4'hB;
  localparam int CFG_SEQ_LSB  = 16;
  localparam int STAT_GRP_LSB = 1;
  localparam int STAT_PND_LSB = 8;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;
  // ==========================================================
  // numeric range
  localparam logic signed [31:0] SAT_MAX = 32'sh7FFF_FFFF;
  localparam logic signed [31:0] SAT_MIN = -32'sh7FFF_FFFF;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    T_ADD = 4'h0, T_AND = 4'h1, T_AVA = 4'h2, T_BSW = 4'h3, T_DFR = 4'h4, T_DIF = 4'h5, T_DIV = 4'h6,
    T_INT = 4'h7, T_LIM = 4'h8, T_LVM = 4'h9, T_MFP = 4'hA, T_MUL = 4'hB, T_NCM = 4'hC
  } blk_type_t;
  typedef struct packed {
    logic [14:0] seq;
    logic [2:0]  grp;
  } cfg_t;
  function automatic blk_type_t slot_type(input int i);
    int b;
    b = N_ADD;
    if (i < b) return T_ADD;
    b += N_AND; if (i < b) return T_AND;
    b += N_AVA; if (i < b) return T_AVA;
    b += N_BSW; if (i < b) return T_BSW;
    b += N_DFR; if (i < b) return T_DFR;
    b += N_DIF; if (i < b) return T_DIF;
    b += N_DIV; if (i < b) return T_DIV;
    b += N_INT; if (i < b) return T_INT;
    b += N_LIM; if (i < b) return T_LIM;
    b += N_LVM; if (i < b) return T_LVM;
    b += N_MFP; if (i < b) return T_MFP;
    b += N_MUL; if (i < b) return T_MUL;
    return T_NCM;
  endfunction
  function automatic logic signed [31:0] sat(input logic signed [127:0] v);
    if (v > SAT_MAX) return SAT_MAX;
    if (v < SAT_MIN) return SAT_MIN;
    return v[31:0];
  endfunction
endpackage
`default_nettype wire

//--- rtl/free_function_block_engine.sv
// Overview of operation
// - unassigned block (group 0) is never evaluated
// - six groups paced every 8..256 ms
// - numeric, timer blocks only in groups 5, 6
// - blocks evaluated in ascending run sequence, 0..32000
// - adder sums four inputs, saturated
// - AND output 1 only if all inputs 1
// - absolute value output, sign flag when negative
// - binary switch picks input by select
// - D flip-flop reset dominant, set, triggered load
// - differentiator scales input delta by TD/cycle
// - divider saturates, 0/0 keeps previous output
// - divider quotient, remainder, fault on overflow/zero
// - integrator adds input times cycle/TI
// - integrator output clamped to limits while set input is 0
// - integrator set input forces preset value
// - limiter clamps, flags upper and lower reach
// - limit monitor: above, within, below band flags
// - pulse generator, not retriggerable during pulse
// - multiplier product of four inputs, saturated
// - comparator sets exactly one of three flags
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module free_function_block_engine #(
  parameter int MS_CYCLES = ffb_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);
  import ffb_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES);

  // ==========================================================
  // storage
  cfg_t                    cfg_r  [NUM_SLOTS];
  logic signed [31:0]      xin_r  [NUM_SLOTS][4];
  logic        [3:0]       bin_r  [NUM_SLOTS];
  logic signed [31:0]      par_r  [NUM_SLOTS];
  logic signed [31:0]      y_r    [NUM_SLOTS];
  logic signed [31:0]      yq_r   [NUM_SLOTS];
  logic signed [31:0]      yr_r   [NUM_SLOTS];
  logic        [3:0]       bo_r   [NUM_SLOTS];
  logic signed [31:0]      st_r   [NUM_SLOTS];
  logic                    run_en_r;

  // ==========================================================
  // ahb-lite slave
  logic                    wr_pend_r;
  logic [11:0]             wr_addr_r;
  logic                    rd_wait_r;
  logic [11:0]             rd_addr_r;
  logic [31:0]             hrdata_r;
  logic [31:0]             rd_mux;
  logic                    accept;

  function automatic logic slot_hit(input logic [11:0] a);
    return (a[11:6] >= SLOT_BASE_BLK) && (int'(a[11:6] - SLOT_BASE_BLK) < NUM_SLOTS);
  endfunction

  function automatic int slot_idx(input logic [11:0] a);
    return int'(a[11:6] - SLOT_BASE_BLK);
  endfunction

  assign accept        = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ;
  assign hreadyout_out = ~rd_wait_r;
  assign hresp_out     = HRESP_OKAY;
  assign hrdata_out    = hrdata_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rd_wait_r <= 1'b0;
      rd_addr_r <= '0;
    end else begin
      wr_pend_r <= accept && hwrite_in;
      rd_wait_r <= accept && !hwrite_in;
      if (accept) begin
        wr_addr_r <= haddr_in[11:0];
        rd_addr_r <= haddr_in[11:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_r <= REG_RST;
    end else if (rd_wait_r) begin
      hrdata_r <= rd_mux;
    end
  end

  // software-written configuration and inputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      run_en_r <= 1'b0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        cfg_r[i] <= '0;
        bin_r[i] <= '0;
        par_r[i] <= '0;
        for (int k = 0; k < 4; k++) begin
          xin_r[i][k] <= '0;
        end
      end
    end else if (wr_pend_r) begin
      if (wr_addr_r == CTRL_OFS) begin
        run_en_r <= hwdata_in[0];
      end else if (slot_hit(wr_addr_r)) begin
        unique case (wr_addr_r[5:2]) inside
          W_CFG: begin
            cfg_r[slot_idx(wr_addr_r)].grp <= hwdata_in[2:0];
            cfg_r[slot_idx(wr_addr_r)].seq <= (hwdata_in[CFG_SEQ_LSB +: 15] > SEQ_MAX) ?
                                               SEQ_MAX : hwdata_in[CFG_SEQ_LSB +: 15];
          end
          [W_X0:W_X3]: xin_r[slot_idx(wr_addr_r)][int'(wr_addr_r[5:2] - W_X0)] <= hwdata_in;
          W_BIN: bin_r[slot_idx(wr_addr_r)] <= hwdata_in[3:0];
          W_PAR: par_r[slot_idx(wr_addr_r)] <= hwdata_in;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // group pacing
  logic [MSW-1:0]          ms_div_r;
  logic [7:0]              ms_cnt_r;
  logic [7:0]              ms_nxt;
  logic                    ms_tick;
  logic [NUM_GRP-1:0]      pend_r;
  logic [NUM_GRP-1:0]      pend_set;
  logic [NUM_GRP-1:0]      pend_clr;

  assign ms_tick = ms_div_r == MSW'(MS_CYCLES - 1);
  assign ms_nxt  = ms_cnt_r + 8'h01;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ms_div_r <= '0;
      ms_cnt_r <= '0;
    end else begin
      ms_div_r <= ms_tick ? '0 : ms_div_r + MSW'(1);
      if (ms_tick) begin
        ms_cnt_r <= ms_nxt;
      end
    end
  end

  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      pend_set[g] = run_en_r && ms_tick && ((ms_nxt & 8'((16'(SLICE1_MS) << g) - 16'h1)) == 8'h00);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  // ==========================================================
  // scheduler
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_RUN = 2'b10} eng_state_t;
  eng_state_t              state_r;
  logic [2:0]              cur_grp_r;
  logic                    first_r;
  logic [19:0]             last_key_r;
  logic                    found;
  int                      sel;
  logic [19:0]             best;
  logic [2:0]              low_grp;

  function automatic logic grp_ok(input blk_type_t t, input logic [2:0] g);
    logic any_grp;
    any_grp = (t == T_AND) || (t == T_BSW) || (t == T_DFR);
    return (g != 3'h0) && (int'(g) <= NUM_GRP) && (any_grp || int'(g) >= NUM_MIN_GRP);
  endfunction

  always_comb begin
    found = 1'b0;
    sel   = 0;
    best  = '1;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (cfg_r[i].grp == cur_grp_r && grp_ok(slot_type(i), cfg_r[i].grp) &&
          (first_r || {cfg_r[i].seq, 5'(i)} > last_key_r) && {cfg_r[i].seq, 5'(i)} < best) begin
        found = 1'b1;
        best  = {cfg_r[i].seq, 5'(i)};
        sel   = i;
      end
    end
    low_grp = 3'h0;
    for (int g = NUM_GRP - 1; g >= 0; g--) begin
      if (pend_r[g]) begin
        low_grp = 3'(g + 1);
      end
    end
    pend_clr = '0;
    if (state_r == S_RUN && !found) begin
      pend_clr[cur_grp_r - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r    <= S_IDLE;
      cur_grp_r  <= 3'h0;
      first_r    <= 1'b1;
      last_key_r <= '0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (low_grp != 3'h0) begin
            state_r   <= S_RUN;
            cur_grp_r <= low_grp;
            first_r   <= 1'b1;
          end
        end
        S_RUN: begin
          if (found) begin
            first_r    <= 1'b0;
            last_key_r <= best;
          end else begin
            state_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // block evaluation
  logic signed [31:0]      x0, x1, x2, x3;
  logic        [3:0]       b;
  logic signed [127:0]     w0, w1, w2, w3, wy, wst, wpar, wcyc, wq, wacc;
  logic signed [31:0]      y_n, yq_n, yr_n, st_n;
  logic        [3:0]       bo_n;
  logic                    dq;
  logic                    and_exp;
  blk_type_t               sel_type;

  assign sel_type = slot_type(sel);
  assign and_exp  = &bin_r[sel];

  always_comb begin
    x0   = xin_r[sel][0];
    x1   = xin_r[sel][1];
    x2   = xin_r[sel][2];
    x3   = xin_r[sel][3];
    b    = bin_r[sel];
    w0   = 128'(x0);
    w1   = 128'(x1);
    w2   = 128'(x2);
    w3   = 128'(x3);
    wy   = 128'(y_r[sel]);
    wst  = 128'(st_r[sel]);
    wpar = 128'(par_r[sel]);
    wcyc = 128'(SLICE1_MS) << (cur_grp_r - 3'h1);
    y_n  = y_r[sel];
    yq_n = yq_r[sel];
    yr_n = yr_r[sel];
    st_n = st_r[sel];
    bo_n = bo_r[sel];
    wq   = '0;
    wacc = '0;
    dq   = bo_r[sel][0];
    unique case (sel_type)
      T_ADD: y_n = sat(w0 + w1 + w2 + w3);
      T_MUL: y_n = sat(w0 * w1 * w2 * w3);
      T_AND: bo_n[0] = and_exp;
      T_AVA: begin
        y_n     = (x0 < 0) ? sat(-w0) : x0;
        bo_n[0] = x0 < 0;
      end
      T_BSW: bo_n[0] = b[2] ? b[1] : b[0];
      T_DFR: begin
        if (b[3]) dq = 1'b0;
        else if (b[2]) dq = 1'b1;
        else if (b[0]) dq = b[1];
        bo_n[1:0] = {~dq, dq};
      end
      T_DIF: begin
        y_n  = sat(((w0 - wst) * wpar) / wcyc);
        st_n = x0;
      end
      T_DIV: begin
        if (x1 == 0) begin
          bo_n[0] = 1'b1;
          if (x0 != 0) begin
            y_n  = (x0 < 0) ? SAT_MIN : SAT_MAX;
            yq_n = y_n;
            yr_n = '0;
          end
        end else begin
          wq      = w0 / w1;
          y_n     = sat(wq);
          yq_n    = y_n;
          yr_n    = 32'(w0 % w1);
          bo_n[0] = (wq > SAT_MAX) || (wq < SAT_MIN);
        end
      end
      T_INT: begin
        wacc = (wpar != 0) ? wy + (wcyc * w0) / wpar : wy;
        if (wacc > w3) wacc = w3;
        if (wacc < w2) wacc = w2;
        if (b[0]) wacc = w1;
        y_n = sat(wacc);
      end
      T_LIM: begin
        y_n = (x0 > x1) ? x1 : ((x0 < x2) ? x2 : x0);
        bo_n[1:0] = {x0 <= x2, x0 >= x1};
      end
      T_LVM: begin
        if (w0 > w1 + w2 + w3) bo_n[0] = 1'b1;
        else if (w0 < w1 + w2 - w3) bo_n[0] = 1'b0;
        if (w0 < w1 - w2 - w3) bo_n[2] = 1'b1;
        else if (w0 > w1 - w2 + w3) bo_n[2] = 1'b0;
        bo_n[1] = ~bo_n[0] & ~bo_n[2];
      end
      T_MFP: begin
        if (st_r[sel] == 0 && b[0] && !bo_r[sel][3]) st_n = par_r[sel];
        else st_n = (wst > wcyc) ? 32'(wst - wcyc) : '0;
        bo_n[0] = st_n > 0;
        bo_n[3] = b[0];
      end
      T_NCM: bo_n[2:0] = {x0 < x1, x0 == x1, x0 > x1};
      default: ;
    endcase
  end

  // one instance per slot, fixed type per slot
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        y_r[i]  <= '0;
        yq_r[i] <= '0;
        yr_r[i] <= '0;
        bo_r[i] <= (slot_type(i) == T_DFR) ? 4'h2 : 4'h0;
        st_r[i] <= '0;
      end
    end else if (state_r == S_RUN && found) begin
      y_r[sel]  <= y_n;
      yq_r[sel] <= yq_n;
      yr_r[sel] <= yr_n;
      bo_r[sel] <= bo_n;
      st_r[sel] <= st_n;
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    rd_mux = REG_RST;
    if (rd_addr_r == CTRL_OFS) begin
      rd_mux[0] = run_en_r;
    end else if (rd_addr_r == STAT_OFS) begin
      rd_mux[0] = state_r == S_RUN;
      rd_mux[STAT_GRP_LSB +: 3] = cur_grp_r;
      rd_mux[STAT_PND_LSB +: NUM_GRP] = pend_r;
    end else if (slot_hit(rd_addr_r)) begin
      unique case (rd_addr_r[5:2]) inside
        W_CFG: begin
          rd_mux[2:0] = cfg_r[slot_idx(rd_addr_r)].grp;
          rd_mux[CFG_SEQ_LSB +: 15] = cfg_r[slot_idx(rd_addr_r)].seq;
        end
        [W_X0:W_X3]: rd_mux = xin_r[slot_idx(rd_addr_r)][int'(rd_addr_r[5:2] - W_X0)];
        W_BIN: rd_mux[3:0] = bin_r[slot_idx(rd_addr_r)];
        W_PAR: rd_mux = par_r[slot_idx(rd_addr_r)];
        W_Y:   rd_mux = y_r[slot_idx(rd_addr_r)];
        W_YQ:  rd_mux = yq_r[slot_idx(rd_addr_r)];
        W_YR:  rd_mux = yr_r[slot_idx(rd_addr_r)];
        W_BO:  rd_mux[3:0] = bo_r[slot_idx(rd_addr_r)];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_assigned_only: assert property (
    state_r == S_RUN && found |-> cfg_r[sel].grp != 3'h0 && cfg_r[sel].grp == cur_grp_r)
    else $error("unassigned block evaluated");
  a_grp1_pacing: assert property (
    pend_set[0] |=> pend_r[0] && $past(ms_nxt[2:0]) == 3'h0)
    else $error("group 1 not paced by 8 ms");
  a_numeric_group: assert property (
    state_r == S_RUN && found && !(sel_type inside {T_AND, T_BSW, T_DFR}) |-> cur_grp_r >= 3'h5)
    else $error("numeric block in fast group");
  a_seq_ascending: assert property (
    state_r == S_RUN && found ##1 state_r == S_RUN && found |-> best > $past(best))
    else $error("run sequence not ascending");
  a_and_output: assert property (
    state_r == S_RUN && found && sel_type == T_AND |=> bo_r[$past(sel)][0] == $past(and_exp))
    else $error("and output wrong");
  a_dff_inverse: assert property (
    state_r == S_RUN && found && sel_type == T_DFR |=> bo_r[$past(sel)][1] == ~bo_r[$past(sel)][0])
    else $error("flip-flop outputs not complementary");
  a_cmp_onehot: assert property (
    state_r == S_RUN && found && sel_type == T_NCM |=> $onehot(bo_r[$past(sel)][2:0]))
    else $error("comparator not one-hot");
  a_lim_range: assert property (
    state_r == S_RUN && found && sel_type == T_LIM && x2 <= x1 |-> y_n <= x1 && y_n >= x2)
    else $error("limiter out of range");
  a_read_wait: assert property (
    accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out && hrdata_out == $past(rd_mux))
    else $error("read answer timing wrong");
endmodule // free_function_block_engine
`default_nettype wire

//--- dv/ffb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// ahb-lite master standing in for configuring software
module ffb_host_model (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // command side
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             done_out,
  output logic      [31:0] rdata_out,
  // ahb-lite master
  output logic             hsel_out,
  output logic      [31:0] haddr_out,
  output logic      [1:0]  htrans_out,
  output logic             hwrite_out,
  output logic      [2:0]  hsize_out,
  output logic      [31:0] hwdata_out,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in
);
  import ffb_pkg::*;
  logic [1:0]  ph_r;
  logic [31:0] wd_r;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ph_r <= 2'h0;
      wd_r <= 32'h0000_0000;
      done_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      hsel_out <= 1'b0;
      haddr_out <= 32'h0000_0000;
      htrans_out <= 2'h0;
      hwrite_out <= 1'b0;
      hsize_out <= 3'h2;
      hwdata_out <= 32'h0000_0000;
    end else begin
      done_out <= 1'b0;
      case (ph_r)
        2'h0: begin
          // released address and write data lines invert every cycle
          haddr_out <= ~haddr_out;
          hwdata_out <= ~hwdata_out;
          if (req_in) begin
            hsel_out <= 1'b1;
            haddr_out <= addr_in;
            htrans_out <= HTRANS_NONSEQ;
            hwrite_out <= wr_in;
            wd_r <= wdata_in;
            ph_r <= 2'h1;
          end
        end
        2'h1: if (hready_in) begin
          htrans_out <= 2'h0;
          hwdata_out <= wd_r;
          ph_r <= 2'h2;
        end
        default: if (hready_in) begin
          rdata_out <= hrdata_in;
          done_out <= 1'b1;
          hsel_out <= 1'b0;
          ph_r <= 2'h0;
        end
      endcase
    end
  end
endmodule // ffb_host_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ffb_pkg::*;
  localparam int MSC = 10;
  logic              clk_sys_in;
  logic              rst_in;
  logic              req;
  logic              wr;
  logic              done;
  logic              hsel;
  logic              hwrite;
  logic              hready;
  logic              hresp;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       addr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [31:0]       seed;
  logic signed [31:0] x [4];
  logic [3:0]        bin;
  logic              q;
  int                bad_count;
  int                checked;
  int                cyc;
  int                cfg_slot [12] = '{0, 1, 2, 3, 7, 9, 11, 15, 16, 18, 26, 28};
  int                cfg_grp  [12] = '{5, 1, 0, 1, 5, 2, 3, 5, 5, 5, 6, 5};
  int                num_slot [7]  = '{0, 1, 2, 26, 15, 7, 28};
  // ==========================================================
  // design and host
  free_function_block_engine #(.MS_CYCLES(MSC)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp));
  ffb_host_model host_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req), .wr_in(wr), .addr_in(addr), .wdata_in(wdata),
    .done_out(done), .rdata_out(rdata), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata), .hready_in(hready), .hrdata_in(hrdata));
  initial clk_sys_in = 1'b0;
  always #5 clk_sys_in = ~clk_sys_in;
  // ==========================================================
  // helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_in);
    req <= 1'b0;
    while (done !== 1'b1) @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [31:0] sa(input int s, input logic [3:0] w);
    return 32'h0000_0100 + 32'(s) * 32'h0000_0040 + 32'(w) * 32'h0000_0004;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] clip(input logic signed [127:0] v);
    if (v > 128'sh7FFF_FFFF) return 32'h7FFF_FFFF;
    if (v < -128'sh7FFF_FFFF) return 32'h8000_0001;
    return v[31:0];
  endfunction
  // ==========================================================
  // main sequence
  initial begin : main_seq
    logic signed [127:0] s;
    logic signed [127:0] p;
    rst_in = 1'b1;
    req = 1'b0;
    wr = 1'b0;
    addr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    seed = 32'h0000_66DE;
    q = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd({20'h0_0000, CTRL_OFS});
    chk(rdata, REG_RST);
    rd(sa(11, W_BO));
    chk(rdata & 32'h0000_0003, 32'h0000_0002);
    rd(32'h0000_0008);
    chk(rdata, 32'h0000_0000);
    bus(1'b1, sa(0, W_Y), 32'h0000_1234);
    rd(sa(0, W_Y));
    chk(rdata, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, sa(cfg_slot[i], W_CFG), ((rnd() % 32001) << CFG_SEQ_LSB) | 32'(cfg_grp[i]));
    end
    bus(1'b1, sa(18, W_X0 + 4'h1), 32'h0000_0014);
    bus(1'b1, sa(18, W_X0 + 4'h2), 32'hFFFF_FFEC);
    bus(1'b1, sa(16, W_X0), 32'h0000_0005);
    bus(1'b1, sa(16, W_X0 + 4'h1), 32'h0000_0000);
    // integrator held at preset, monitor above band, long pulse, steady differentiator input
    bus(1'b1, sa(17, W_CFG), 32'h0000_0005);
    bus(1'b1, sa(17, W_X0 + 4'h1), 32'h0000_0077);
    bus(1'b1, sa(17, W_BIN), 32'h0000_0001);
    bus(1'b1, sa(20, W_CFG), 32'h0000_0005);
    bus(1'b1, sa(20, W_X0), 32'h0000_0064);
    bus(1'b1, sa(20, W_X0 + 4'h2), 32'h0000_000A);
    bus(1'b1, sa(20, W_X0 + 4'h3), 32'h0000_0002);
    bus(1'b1, sa(22, W_CFG), 32'h0000_0005);
    bus(1'b1, sa(22, W_PAR), 32'h0000_7530);
    bus(1'b1, sa(22, W_BIN), 32'h0000_0001);
    bus(1'b1, sa(14, W_CFG), 32'h0000_0005);
    bus(1'b1, sa(14, W_PAR), 32'h0000_0004);
    bus(1'b1, sa(14, W_X0), 32'h0000_0040);
    bus(1'b1, {20'h0_0000, CTRL_OFS}, 32'h0000_0001);
    for (int it = 0; it < 3; it++) begin
      for (int k = 0; k < 4; k++) x[k] = $signed(rnd() & 32'h0000_00FF) - 32'sd128;
      if (it == 0) x = '{32'sh7FFF_0000, 32'sh7FFF_0000, 32'sh1, 32'sh2};
      if (x[1] == 0) x[1] = 32'sh1;
      bin = (it == 0) ? 4'hF : 4'(rnd() & 32'h0000_000F);
      for (int i = 0; i < 7; i++) begin
        for (int k = 0; k < 4; k++) bus(1'b1, sa(num_slot[i], W_X0 + 4'(k)), x[k]);
      end
      bus(1'b1, sa(18, W_X0), x[0]);
      bus(1'b1, sa(3, W_BIN), {28'h000_0000, bin});
      bus(1'b1, sa(9, W_BIN), {28'h000_0000, bin});
      bus(1'b1, sa(11, W_BIN), {28'h000_0000, bin});
      if (bin[3]) q = 1'b0;
      else if (bin[2]) q = 1'b1;
      else if (bin[0]) q = bin[1];
      repeat (2 * 256 * MSC + 200) @(posedge clk_sys_in);
      s = x[0];
      s = s + x[1] + x[2] + x[3];
      p = x[0];
      p = p * x[1] * x[2] * x[3];
      rd(sa(0, W_Y));
      chk(rdata, clip(s));
      rd(sa(1, W_Y));
      chk(rdata, 32'h0000_0000);
      rd(sa(2, W_Y));
      chk(rdata, 32'h0000_0000);
      rd(sa(26, W_Y));
      chk(rdata, clip(p));
      rd(sa(7, W_Y));
      chk(rdata, (x[0] < 0) ? -x[0] : x[0]);
      rd(sa(7, W_BO));
      chk(rdata & 32'h0000_0001, {31'h0, x[0] < 0});
      rd(sa(28, W_BO));
      chk(rdata & 32'h0000_0007, {29'h0, x[0] < x[1], x[0] == x[1], x[0] > x[1]});
      rd(sa(15, W_YQ));
      chk(rdata, x[0] / x[1]);
      rd(sa(15, W_YR));
      chk(rdata, x[0] % x[1]);
      rd(sa(15, W_BO));
      chk(rdata & 32'h0000_0001, 32'h0000_0000);
      rd(sa(16, W_Y));
      chk(rdata, 32'h7FFF_FFFF);
      rd(sa(16, W_BO));
      chk(rdata & 32'h0000_0001, 32'h0000_0001);
      rd(sa(18, W_Y));
      chk(rdata, (x[0] > 20) ? 32'h0000_0014 : (x[0] < -20) ? 32'hFFFF_FFEC : x[0]);
      rd(sa(18, W_BO));
      chk(rdata & 32'h0000_0003, {30'h0, x[0] <= -20, x[0] >= 20});
      rd(sa(3, W_BO));
      chk(rdata & 32'h0000_0001, {31'h0, &bin});
      rd(sa(9, W_BO));
      chk(rdata & 32'h0000_0001, {31'h0, bin[2] ? bin[1] : bin[0]});
      rd(sa(11, W_BO));
      chk(rdata & 32'h0000_0003, {30'h0, ~q, q});
      rd(sa(17, W_Y));
      chk(rdata, 32'h0000_0077);
      rd(sa(20, W_BO));
      chk(rdata & 32'h0000_0007, 32'h0000_0001);
      rd(sa(22, W_BO));
      chk(rdata & 32'h0000_0001, 32'h0000_0001);
      rd(sa(14, W_Y));
      chk(rdata, 32'h0000_0000);
    end
    close_out();
  end
endmodule // tb_top
`default_nettype wire
